// ---- test/tb_wakeup_clock_masking.sv ----
// Purpose: self-checking bench for the masking device and its sequencer
// Assumes: 200 MHz clock, shortened mask and overshoot counts
// Notes: rows cover every core level and both mask lengths
`timescale 1ns/1ps
module tb_wakeup_clock_masking
    import wcm_pkg::*;
();
    localparam int ML = 500; // shortened long mask
    localparam int OS = 50; // shortened overshoot
    typedef struct packed {
        logic [3:0] cfg; // supervisor bits
        logic [3:0] ctl; // level, keep, crystal
        logic [15:0] osc; // oscillator kHz
        logic fast; // short mask expected
        logic sub; // sub overshoot expected
    } wcm_row_type;
    // limits are probed one kHz above, the level 0 limit also at the limit itself, since the compare is strict
    localparam wcm_row_type ROWS [7] = '{
        '{4'h0, 4'h0, 16'h1389, 1'b1, 1'b1}, '{4'h0, 4'h0, 16'h1388, 1'b0, 1'b1},
        '{4'hF, 4'h5, 16'h1D4D, 1'b1, 1'b0}, '{4'h3, 4'hA, 16'h4E20, 1'b0, 1'b0},
        '{4'h5, 4'hC, 16'h30D5, 1'b0, 1'b1}, '{4'hC, 4'hC, 16'h30D5, 1'b1, 1'b1},
        '{4'hA, 4'h8, 16'h2711, 1'b0, 1'b1}};
    logic clk = 1'b0, rst_n = 1'b0; // clock, reset
    logic wr = 1'b0, rd = 1'b0, wake_in = 1'b0; // strobes, wake
    logic [3:0] addr = 4'h0; // address
    logic [15:0] wdata = 16'h0000, osc_khz_in = 16'h0000; // inputs
    logic [15:0] rdata, mask_left; // outputs
    int fails = 0, checked = 0, n; // counters
    wcm_link_if link ();
    always #2.5 clk = ~clk;
    wcm_device #(.MASK_LONG(ML), .OVERSHOOT(OS)) i_wcm_device (.clk(clk), .rst_n(rst_n), .link(link),
        .mask_left(mask_left));
    wcm_soft i_wcm_soft (.clk(clk), .rst_n(rst_n), .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .wake_in(wake_in), .osc_khz_in(osc_khz_in));
    wcm_link_monitor #(.MASK_LONG(ML), .OVERSHOOT(OS)) i_wcm_link_monitor (.clk(clk), .rst_n(rst_n),
        .sleep_req(link.sleep_req), .wake_event(link.wake_event), .low_monitor_enable(link.low_monitor_enable),
        .low_supervisor_enable(link.low_supervisor_enable), .low_monitor_full_perf(link.low_monitor_full_perf),
        .low_supervisor_full_perf(link.low_supervisor_full_perf), .core_level(link.core_level),
        .osc_khz(link.osc_khz), .main_from_osc(link.main_from_osc), .sub_from_crystal(link.sub_from_crystal),
        .sub_clock_request_enable(link.sub_clock_request_enable), .main_clock_divider(link.main_clock_divider),
        .sub_periph_enable(link.sub_periph_enable), .asleep(link.asleep), .cpu_clk_en(link.cpu_clk_en),
        .overshoot(link.overshoot), .sub_overshoot(link.sub_overshoot));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    // read data stands one cycle only, so it is sampled just after the taking edge
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1;
        check(nm, rdata & 16'h000F, e);
    endtask
    // waits for sleep, wakes, then waits for the mask to load
    task automatic sleep_wake();
        for (n = 0; n < 20 && link.asleep !== 1'b1; n++) @(posedge clk) #1;
        check("divider_asleep", link.main_clock_divider, DIV_BY_TWO);
        check("periph_asleep", link.sub_periph_enable, 1'b0);
        @(posedge clk) wake_in <= 1'b1;
        @(posedge clk) wake_in <= 1'b0;
        #1;
        for (n = 0; n < 10 && mask_left === 16'h0000; n++) @(posedge clk) #1;
        check("cpu_masked", link.cpu_clk_en, 1'b0);
    endtask
    task automatic final_report();
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 7; r++) begin
            @(posedge clk) osc_khz_in <= ROWS[r].osc;
            wr_reg(CFG_OFS, {12'h000, ROWS[r].cfg});
            wr_reg(CTRL_OFS, {10'h000, ROWS[r].ctl[3:2], 1'b0, ROWS[r].ctl[1:0], 1'b1});
            sleep_wake();
            check("mask_len", mask_left, ROWS[r].fast ? 16'(MASK_SHORT_CYC) : 16'(ML));
            check("overshoot", link.overshoot, 1'b1);
            check("sub_overshoot", link.sub_overshoot, ROWS[r].sub);
            for (n = 0; n < 600 && link.cpu_clk_en !== 1'b1; n++) @(posedge clk) #1;
            check("overshoot_end", link.overshoot, 1'b0);
            for (n = 0; n < 300 && link.main_clock_divider !== DIV_BY_ONE; n++) @(posedge clk) #1;
            check("restore_wait", n >= MAIN_WAIT_CYC[ROWS[r].ctl[3:2]], 1'b1);
            check("periph_on", link.sub_periph_enable, 1'b1);
            rd_chk("status", STAT_OFS, 16'h0002);
        end
        wr_reg(4'hE, 16'hFFFF);
        rd_chk("cfg_back", CFG_OFS, 16'h000A);
        rd_chk("unmapped", 4'hF, 16'h0000);
        // a wake while running must not start a mask
        @(posedge clk) wake_in <= 1'b1;
        @(posedge clk) wake_in <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("wake_awake", mask_left, 16'h0000);
        // reset lands in mid-mask, with the overshoot window still open
        wr_reg(CTRL_OFS, 16'h0001);
        sleep_wake();
        @(posedge clk) rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("reset_cpu", link.cpu_clk_en, 1'b1);
        check("reset_mask", mask_left, 16'h0000);
        check("reset_overshoot", link.overshoot, 1'b0);
        final_report();
    end
    // the run needs about 20 us; a hang is cut off well after that
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule

// ---- test/wcm_link_monitor.sv ----
// Purpose: concurrent checks on the masking link
// Assumes: one clock, sync active-low reset
// Notes: mask lengths get one cycle of slack for the load edge
`timescale 1ns/1ps
module wcm_link_monitor
    import wcm_pkg::*;
#(
    parameter int MASK_LONG = MASK_LONG_CYC, // long mask cycles
    parameter int OVERSHOOT = OVERSHOOT_CYC  // overshoot cycles
) (
    input logic clk, // clock
    input logic rst_n, // reset
    input logic sleep_req, // sleep pulse
    input logic wake_event, // wake pulse
    input logic low_monitor_enable, // monitor on
    input logic low_supervisor_enable, // supervisor on
    input logic low_monitor_full_perf, // monitor fast
    input logic low_supervisor_full_perf, // supervisor fast
    input logic [1:0] core_level, // core level
    input logic [15:0] osc_khz, // oscillator kHz
    input logic main_from_osc, // main on oscillator
    input logic sub_from_crystal, // sub on crystal
    input logic sub_clock_request_enable, // request kept
    input logic [2:0] main_clock_divider, // main divide
    input logic sub_periph_enable, // sub modules run
    input logic asleep, // low power
    input logic cpu_clk_en, // cpu gate
    input logic overshoot, // overshoot window
    input logic sub_overshoot // sub overshoot
);
    logic fast; // short mask condition
    logic armed, fast_q; // wake seen, condition at wake
    logic [15:0] mcnt, os_cnt; // masked and overshoot cycles
    logic [7:0] run_cnt; // cycles since cpu clock returned, saturating
    wire wake_taken = wake_event && asleep; // a wake the device must act on
    assign fast = ((!low_monitor_enable && !low_supervisor_enable) || (low_monitor_full_perf && low_supervisor_full_perf))
        && main_from_osc && osc_khz > FREQ_LIMIT_KHZ[core_level];
    // bookkeeping; the condition is latched at wake since software may change it later
    always_ff @(posedge clk) begin
        armed <= rst_n && (wake_taken || (armed && !cpu_clk_en));
        fast_q <= wake_taken ? fast : fast_q;
        mcnt <= (!rst_n || wake_taken) ? 16'h0000 : mcnt + {15'h0000, !cpu_clk_en};
        os_cnt <= (!rst_n || !overshoot) ? 16'h0000 : os_cnt + 16'h0001;
        run_cnt <= (!rst_n || !cpu_clk_en) ? 8'h00 : run_cnt + {7'h00, run_cnt != 8'hFF};
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_gate_asleep: assert property (asleep |-> !cpu_clk_en) else $error("cpu runs asleep");
    a_mask_long: assert property (armed && cpu_clk_en && !fast_q
        |-> mcnt inside {[MASK_LONG:MASK_LONG + 1]}) else $error("long mask length wrong");
    a_mask_short: assert property (armed && cpu_clk_en && fast_q |-> mcnt inside {[400:401]})
        else $error("short mask length wrong");
    a_overshoot_start: assert property (wake_taken |=> overshoot [*8]) else $error("no overshoot");
    a_overshoot_len: assert property ($fell(overshoot) && $past(rst_n) |-> os_cnt == OVERSHOOT)
        else $error("overshoot length wrong");
    a_sub_carries: assert property (sub_overshoot == (overshoot && !sub_from_crystal && !sub_clock_request_enable))
        else $error("sub overshoot wrong");
    a_divide_sleep: assert property (sleep_req |-> (main_clock_divider == DIV_BY_TWO) [*4])
        else $error("main clock not halved");
    a_divider_restore: assert property ($past(rst_n) && $past(main_clock_divider) == DIV_BY_TWO
        && main_clock_divider == DIV_BY_ONE |-> run_cnt >= MAIN_WAIT_CYC[core_level]) else $error("restore too early");
    a_periph_halted: assert property (asleep || !cpu_clk_en |-> !sub_periph_enable) else $error("periph runs");
    c_fast_wake: cover property (armed && cpu_clk_en && fast_q);
    c_slow_wake: cover property (armed && cpu_clk_en && !fast_q);
    c_sub_hazard: cover property (sub_overshoot);
endmodule

// ---- verilog/wcm_device.sv ----
// Purpose: wake-up execution mask and oscillator overshoot window after deep sleep
// Assumes: wake_event is a one-cycle pulse, configuration steady while asleep
// Notes: the sub clock is never masked; its overshoot flag only reports the hazard
// Functional notes
// - oscillator overshoots at most 6 us after wake
// - normal-performance supervisor masks execution 150 us
// - fast oscillator and condition shrink mask 2 us
// - condition: both enables off or both full-perf
// - software halves main clock before sleep
// - software waits per level before full speed
// - sub clock is unmasked, carries overshoot
// - software uses crystal or keeps request set; wcm_soft just copies control word bits 1 and 2, both zero at reset
// - software halts sub-clock modules, waits per level
`timescale 1ns/1ps
module wcm_device
    import wcm_pkg::*;
#(
    parameter int MASK_LONG = MASK_LONG_CYC, // long mask, shorten for simulation
    parameter int OVERSHOOT = OVERSHOOT_CYC  // overshoot window length
) (
    input wire logic clk,          // system clock
    input wire logic rst_n,        // synchronous reset, active low
    wcm_link_if.dev link,          // link to the software side
    output logic [CNT_W-1:0] mask_left // remaining mask cycles
);
    logic asleep_reg, asleep_next;           // in deep sleep
    logic [CNT_W-1:0] mask_reg, mask_next;   // execution mask counter
    logic [CNT_W-1:0] os_reg, os_next;       // overshoot window counter
    wire sv_fast;                            // supervisor allows fast wake
    wire osc_fast;                           // oscillator above level threshold
    wire short_mask;                         // mask shrinks to 2 us
    wire [CNT_W-1:0] mask_load;              // count loaded on wake
    wire wake;                               // qualified wake pulse

    // fast wake when both off or both in full performance
    assign sv_fast = (!link.low_monitor_enable && !link.low_supervisor_enable) ||
                     (link.low_monitor_full_perf && link.low_supervisor_full_perf);
    assign osc_fast = link.main_from_osc && (link.osc_khz > FREQ_LIMIT_KHZ[link.core_level]);
    assign short_mask = sv_fast && osc_fast;
    // long mask follows the parameter so simulation can shorten it
    assign mask_load = short_mask ? wcm_mask_len(1'b1) : CNT_W'(MASK_LONG);
    assign wake = asleep_reg && link.wake_event;

    // sleep entry and exit
    always_comb begin
        asleep_next = asleep_reg;
        if (wake) begin
            asleep_next = 1'b0;
        end else if (link.sleep_req) begin
            asleep_next = 1'b1;
        end
    end

    // mask counter starts on wake and counts down to zero
    always_comb begin
        mask_next = mask_reg;
        if (wake) begin
            mask_next = mask_load;
        end else if (mask_reg != '0) begin
            mask_next = mask_reg - 1'b1;
        end
    end

    // overshoot window, the oscillator runs fast this long after wake
    always_comb begin
        os_next = os_reg;
        if (wake) begin
            os_next = CNT_W'(OVERSHOOT);
        end else if (os_reg != '0) begin
            os_next = os_reg - 1'b1;
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            asleep_reg <= 1'b0;
            mask_reg <= '0;
            os_reg <= '0;
        end else begin
            asleep_reg <= asleep_next;
            mask_reg <= mask_next;
            os_reg <= os_next;
        end
    end

    // processor clock gated while asleep or masked
    assign link.cpu_clk_en = !asleep_reg && (mask_reg == '0);
    assign link.asleep = asleep_reg;
    assign link.overshoot = os_reg != '0;
    // no mask on the sub clock: it passes the overshoot when oscillator-sourced and requested off
    assign link.sub_overshoot = (os_reg != '0) && !link.sub_from_crystal &&
                                !link.sub_clock_request_enable;
    assign mask_left = mask_reg;
endmodule

// ---- verilog/wcm_link_if.sv ----
// Purpose: link between the clock masking device and its software-side partner
// Assumes: one clock, all signals synchronous
// Notes: the device drives masks and status, the partner drives configuration
`timescale 1ns/1ps
interface wcm_link_if;
    logic sleep_req;          // partner asks for deep sleep
    logic deep_four;          // 1 selects deep_sleep_four, else three
    logic wake_event;         // wake-up pulse
    logic low_monitor_enable;
    logic low_supervisor_enable;
    logic low_monitor_full_perf;
    logic low_supervisor_full_perf;
    logic [1:0] core_level;   // core voltage level 0..3
    logic [15:0] osc_khz;     // tunable_oscillator programmed frequency
    logic main_from_osc;      // main_clock sourced from oscillator
    logic sub_from_crystal;   // sub_main_clock from second_crystal_oscillator
    logic sub_clock_request_enable;
    logic [2:0] main_clock_divider;
    logic sub_periph_enable;  // peripherals on sub_main_clock run
    logic asleep;             // device in low-power mode
    logic cpu_clk_en;         // processor clock gate
    logic overshoot;          // oscillator above programmed frequency
    logic sub_overshoot;      // sub_main_clock carries overshoot
    modport dev (input sleep_req, deep_four, wake_event, low_monitor_enable, low_supervisor_enable,
        low_monitor_full_perf, low_supervisor_full_perf, core_level, osc_khz, main_from_osc,
        sub_from_crystal, sub_clock_request_enable, main_clock_divider, sub_periph_enable,
        output asleep, cpu_clk_en, overshoot, sub_overshoot);
    modport sw (output sleep_req, deep_four, wake_event, low_monitor_enable, low_supervisor_enable,
        low_monitor_full_perf, low_supervisor_full_perf, core_level, osc_khz, main_from_osc,
        sub_from_crystal, sub_clock_request_enable, main_clock_divider, sub_periph_enable,
        input asleep, cpu_clk_en, overshoot, sub_overshoot);
endinterface

// ---- verilog/wcm_pkg.sv ----
// Purpose: shared constants for the wake-up clock masking block and its software-side partner
// Assumes: 200 MHz system clock, all times converted to whole cycles here
// Notes: the overshoot window is a most time, the masks are least times
package wcm_pkg;
    localparam int CLK_MHZ = 200;                          // system clock rate
    localparam int OVERSHOOT_US = 6;                       // oscillator overshoot window
    localparam int MASK_LONG_US = 150;                     // mask in normal-performance mode
    localparam int MASK_SHORT_US = 2;                      // mask in fast wake-up mode
    localparam int OVERSHOOT_CYC = OVERSHOOT_US * CLK_MHZ; // 1200 cycles
    localparam int MASK_LONG_CYC = MASK_LONG_US * CLK_MHZ; // 30000 cycles
    localparam int MASK_SHORT_CYC = MASK_SHORT_US * CLK_MHZ; // 400 cycles
    localparam int CNT_W = 16;                             // mask counter width
    // oscillator threshold in kHz per core level
    localparam logic [15:0] FREQ_LIMIT_KHZ [4] = '{16'h1388, 16'h1D4C, 16'h2710, 16'h30D4};
    // software wait in main-clock cycles per core level
    localparam logic [7:0] MAIN_WAIT_CYC [4] = '{8'h20, 8'h30, 8'h50, 8'h64};
    localparam logic [7:0] SUB_WAIT_CYC [4] = '{8'h20, 8'h30, 8'h40, 8'h50};
    localparam logic [2:0] DIV_BY_ONE = 3'h0;              // main_clock_divider full speed
    localparam logic [2:0] DIV_BY_TWO = 3'h1;              // main_clock_divider halved
    // controller register offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;                // bit0 sleep request, bit1 sub source crystal
    localparam logic [3:0] CFG_OFS = 4'h1;                 // supervisor and monitor bits
    localparam logic [3:0] STAT_OFS = 4'h2;                // status readback
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_XT_BIT = 1;
    localparam int CTRL_KEEPREQ_BIT = 2;
    localparam int CTRL_LEVEL_LSB = 4;
    typedef enum logic [2:0] {
        WCM_ACTIVE = 3'b000,
        WCM_SLEEP = 3'b001,
        WCM_WAKE = 3'b010,
        WCM_WAIT = 3'b011,
        WCM_RESTORE = 3'b100
    } wcm_state_type;
    // cycles to hold the core off for the given supervisor and clock setting
    function automatic logic [CNT_W-1:0] wcm_mask_len(input logic fast);
        wcm_mask_len = fast ? CNT_W'(MASK_SHORT_CYC) : CNT_W'(MASK_LONG_CYC);
    endfunction
endpackage

// ---- verilog/wcm_soft.sv ----
// Purpose: software-side sequencer for deep sleep entry and wake-up
// Assumes: registers reached over a plain strobe port, read data one cycle later
// Notes: waits count system cycles as stand-ins for main-clock cycles
`timescale 1ns/1ps
module wcm_soft
    import wcm_pkg::*;
(
    input wire logic clk,              // system clock
    input wire logic rst_n,            // synchronous reset, active low
    wcm_link_if.sw link,               // link to the device
    input wire logic [3:0] addr,       // register address
    input wire logic [15:0] wdata,     // write data
    input wire logic wr,               // write strobe
    input wire logic rd,               // read strobe
    output logic [15:0] rdata,         // read data, valid cycle after rd
    input wire logic wake_in,          // external wake source
    input wire logic [15:0] osc_khz_in // oscillator setting
);
    wcm_state_type st_reg, st_next;       // sequencer state
    logic [15:0] ctrl_reg;                // control word
    logic [3:0] cfg_reg;                  // supervisor and monitor bits
    logic [7:0] wait_reg, wait_next;      // wait counter
    logic [15:0] rdata_reg;               // read data
    wire [1:0] level;                     // core level
    wire sleep_go;                        // sleep request bit
    wire [7:0] wait_len;                  // longer of the two waits

    assign level = ctrl_reg[CTRL_LEVEL_LSB +: 2];
    assign sleep_go = ctrl_reg[CTRL_SLEEP_BIT];
    // one wait covers both the main divider and the sub-clock modules
    assign wait_len = (MAIN_WAIT_CYC[level] > SUB_WAIT_CYC[level]) ? MAIN_WAIT_CYC[level] :
                      SUB_WAIT_CYC[level];

    // sequencer
    always_comb begin
        st_next = st_reg;
        wait_next = wait_reg;
        case (st_reg)
            WCM_ACTIVE: begin
                if (sleep_go) begin
                    st_next = WCM_SLEEP;
                end
            end
            WCM_SLEEP: begin
                st_next = WCM_WAKE;
            end
            WCM_WAKE: begin
                if (link.cpu_clk_en) begin
                    st_next = WCM_WAIT;
                    wait_next = wait_len;
                end
            end
            WCM_WAIT: begin
                if (wait_reg != 8'h00) begin
                    wait_next = wait_reg - 8'h01;
                end else begin
                    st_next = WCM_RESTORE;
                end
            end
            WCM_RESTORE: begin
                st_next = WCM_ACTIVE;
            end
            default: begin
                st_next = WCM_ACTIVE;
            end
        endcase
    end

    // state and registers; the sleep bit self-clears once entry begins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= WCM_ACTIVE;
            wait_reg <= 8'h00;
            ctrl_reg <= 16'h0000;
            cfg_reg <= 4'h0;
            rdata_reg <= 16'h0000;
        end else begin
            st_reg <= st_next;
            wait_reg <= wait_next;
            if (wr && addr == CTRL_OFS) begin
                ctrl_reg <= wdata;
            end else if (st_reg == WCM_ACTIVE && sleep_go) begin
                ctrl_reg[CTRL_SLEEP_BIT] <= 1'b0;
            end
            if (wr && addr == CFG_OFS) begin
                cfg_reg <= wdata[3:0];
            end
            if (rd && addr == CTRL_OFS) begin
                rdata_reg <= ctrl_reg;
            end else if (rd && addr == CFG_OFS) begin
                rdata_reg <= {12'h000, cfg_reg};
            end else if (rd && addr == STAT_OFS) begin
                rdata_reg <= {9'h000, st_reg, link.sub_overshoot, link.overshoot, link.cpu_clk_en, link.asleep};
            end else begin
                rdata_reg <= 16'h0000;
            end
        end
    end

    assign rdata = rdata_reg;
    assign link.sleep_req = st_reg == WCM_SLEEP;
    assign link.deep_four = 1'b0;
    assign link.wake_event = wake_in;
    assign link.low_monitor_enable = cfg_reg[0];
    assign link.low_supervisor_enable = cfg_reg[1];
    assign link.low_monitor_full_perf = cfg_reg[2];
    assign link.low_supervisor_full_perf = cfg_reg[3];
    assign link.core_level = level;
    assign link.osc_khz = osc_khz_in;
    assign link.main_from_osc = 1'b1;
    assign link.sub_from_crystal = ctrl_reg[CTRL_XT_BIT];
    assign link.sub_clock_request_enable = ctrl_reg[CTRL_KEEPREQ_BIT];
    // halved from sleep entry until the wait ends
    assign link.main_clock_divider = (st_reg == WCM_ACTIVE) ? DIV_BY_ONE : DIV_BY_TWO;
    // sub-clock modules halted from sleep until the wait ends
    assign link.sub_periph_enable = (st_reg == WCM_ACTIVE);
endmodule
